// ---- hdl/hcv_pkg.sv ----
// constants and types shared by the half/single converter files
// ----------------------------------------------------------------------------
// Summary of operation
// - two operations: widen half to single, narrow single to half.
// - immediate bits 1:0 pick rounding: nearest-even, down, up, truncate.
// - immediate bit 2 clear uses immediate rounding, set uses control rounding.
// - immediate bits 7:3 are ignored entirely.
// - quiet NaN narrows keeping sign, exponent all ones, top fraction bits.
// - signaling NaN narrows likewise with the quiet bit forced to one.
// - NaN source sets invalid; unmasked signaling NaN writes no result.
// - denormal single source sets denormal; denormal half source does not.
// - narrowed result below 2^-14 sets underflow, plus precision if inexact.
// - narrowing ignores flush-to-zero, acting as if it were clear.
// - narrowed result at or above 2^16 sets overflow; masked gives infinity.
// - inexact narrowing sets precision; rounded result unless unmasked under/overflow, or denormal source with denormal or precision unmasked.
// - denormal masked, precision or underflow unmasked: raise denormal, underflow, precision.
// - capability bit 29 for conversion, bit 28 for vector extension.
// - half values only converted, never used for arithmetic.
// ----------------------------------------------------------------------------
`default_nettype none
package hcv_pkg;

  // register map (byte offsets)
  localparam logic [7:0]  HCV_OFF_CTRL      = 8'h00;
  localparam logic [7:0]  HCV_OFF_STATUS    = 8'h04;
  localparam logic [7:0]  HCV_OFF_IRQ_MASK  = 8'h08;
  localparam logic [7:0]  HCV_OFF_FEATURE   = 8'h0C;

  // control register fields
  localparam int          HCV_CTRL_RND_LSB  = 0;
  localparam int          HCV_CTRL_MASK_LSB = 2;
  localparam int          HCV_CTRL_FLS_BIT  = 7;
  localparam logic [7:0]  HCV_CTRL_RST      = 8'h7C;
  localparam logic [4:0]  HCV_IRQ_MASK_RST  = 5'h00;

  // flag positions in status, masks and exception flags
  localparam int          HCV_NFLAGS        = 5;
  localparam int          HCV_FLG_INV       = 0;
  localparam int          HCV_FLG_DEN       = 1;
  localparam int          HCV_FLG_OVF       = 2;
  localparam int          HCV_FLG_UNF       = 3;
  localparam int          HCV_FLG_PRC       = 4;

  // capability word
  localparam int          HCV_FEAT_VEC_BIT  = 28;
  localparam int          HCV_FEAT_HALF_BIT = 29;

  // immediate byte
  localparam int          HCV_IMM_SEL_BIT   = 2;

  // number formats
  localparam logic [7:0]  HCV_F32_EXP_MAX   = 8'hFF;
  localparam logic [4:0]  HCV_F16_EXP_MAX   = 5'h1F;
  localparam logic [7:0]  HCV_EXP_REBIAS    = 8'h70;
  localparam logic [7:0]  HCV_SUB_EXP_BASE  = 8'h67;
  localparam int          HCV_NAN_DROP      = 14;
  localparam logic signed [9:0] HCV_RND_SHIFT = 10'sh00D;
  localparam logic signed [9:0] HCV_SHIFT_CAP = 10'sh01A;
  localparam logic signed [9:0] HCV_F16_EXP_TOP = 10'sh01E;

  typedef enum logic [1:0] {
    HCV_RN = 2'h0,
    HCV_RD = 2'h1,
    HCV_RU = 2'h2,
    HCV_RZ = 2'h3
  } hcv_rmode_t;

  typedef enum logic {
    HCV_APB_IDLE = 1'b0,
    HCV_APB_ACK  = 1'b1
  } hcv_apb_state_t;

endpackage
`default_nettype wire

// ---- hdl/hcv_reg_if.sv ----
// link between converter core and its register file
`timescale 1ns/10ps
`default_nettype none
interface hcv_reg_if;
  logic [1:0] rounding_control_field;
  logic [4:0] masks;
  logic       flush_to_zero;
  logic       set_valid;
  logic [4:0] set_flags;

  modport regs (output rounding_control_field, output masks, output flush_to_zero,
                input set_valid, input set_flags);
  modport core (input rounding_control_field, input masks, input flush_to_zero,
                output set_valid, output set_flags);
endinterface
`default_nettype wire

// ---- hdl/hcv_regs.sv ----
// APB register file of the half/single converter
`timescale 1ns/10ps
`default_nettype none
module hcv_regs (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output var  logic [31:0] prdata_out,
  output var  logic        pready_out,
  output var  logic        pslverr_out,
  output var  logic        irq_out,
  // core side
  hcv_reg_if.regs          rif
);
  import hcv_pkg::*;

  typedef struct packed {
    hcv_apb_state_t apb_state;
    logic [31:0]    prdata;
    logic           pslverr;
    logic [7:0]     ctrl;
    logic [4:0]     status;
    logic [4:0]     irq_mask;
    logic           irq;
  } hcv_regs_state_t;

  hcv_regs_state_t st;
  hcv_regs_state_t next_st;
  logic            access;
  logic            wr;
  logic [4:0]      clr;

  always_comb begin
    next_st = st;
    clr     = 5'h00;
    access  = psel_in && penable_in && (st.apb_state == HCV_APB_IDLE);
    // a write lands only at the edge where the master sees pready
    wr      = psel_in && penable_in && pwrite_in && (st.apb_state == HCV_APB_ACK);
    next_st.apb_state = access ? HCV_APB_ACK : HCV_APB_IDLE;
    if (wr) begin
      case (paddr_in)
        HCV_OFF_CTRL:     next_st.ctrl     = pwdata_in[7:0];
        HCV_OFF_STATUS:   clr              = pwdata_in[4:0];
        HCV_OFF_IRQ_MASK: next_st.irq_mask = pwdata_in[4:0];
        default:          clr              = 5'h00;
      endcase
    end
    if (access) begin
      next_st.prdata  = 32'h0000_0000;
      next_st.pslverr = 1'b0;
      case (paddr_in)
        HCV_OFF_CTRL:     next_st.prdata = {24'h00_0000, st.ctrl};
        HCV_OFF_STATUS:   next_st.prdata = {27'h000_0000, st.status};
        HCV_OFF_IRQ_MASK: next_st.prdata = {27'h000_0000, st.irq_mask};
        HCV_OFF_FEATURE: begin
          next_st.prdata[HCV_FEAT_VEC_BIT]  = 1'b1;
          next_st.prdata[HCV_FEAT_HALF_BIT] = 1'b1;
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    // a flag raised in the clearing cycle survives the clear
    next_st.status = (st.status & ~clr) | (rif.set_valid ? rif.set_flags : 5'h00);
    next_st.irq    = |(next_st.status & next_st.irq_mask);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      st <= '{apb_state: HCV_APB_IDLE, prdata: 32'h0000_0000, pslverr: 1'b0,
              ctrl: HCV_CTRL_RST, status: 5'h00, irq_mask: HCV_IRQ_MASK_RST, irq: 1'b0};
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign prdata_out  = st.prdata;
  assign pready_out  = (st.apb_state == HCV_APB_ACK);
  assign pslverr_out = st.pslverr;
  assign irq_out     = st.irq;
  assign rif.rounding_control_field = st.ctrl[HCV_CTRL_RND_LSB +: 2];
  assign rif.masks                  = st.ctrl[HCV_CTRL_MASK_LSB +: HCV_NFLAGS];
  assign rif.flush_to_zero          = st.ctrl[HCV_CTRL_FLS_BIT];
endmodule // hcv_regs
`default_nettype wire

// ---- hdl/hcv_converter.sv ----
// packed half/single floating-point converter with APB control registers
`timescale 1ns/10ps
`default_nettype none
module hcv_converter #(
  parameter int LANES = 4
) (
  // clock, reset, enable
  input  wire logic                  ref_clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  ce_in,
  // apb slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [7:0]            paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output var  logic [31:0]           prdata_out,
  output var  logic                  pready_out,
  output var  logic                  pslverr_out,
  // operation from the pipeline
  input  wire logic                  op_valid_in,
  input  wire logic                  op_narrow_in,
  input  wire logic [7:0]            op_imm_in,
  input  wire logic [LANES*32-1:0]   op_src_in,
  // result to the register file
  output var  logic                  res_valid_out,
  output var  logic                  res_write_out,
  output var  logic [LANES*32-1:0]   res_data_out,
  output var  logic                  exc_out,
  output var  logic [4:0]            exc_flags_out,
  // interrupt
  output var  logic                  irq_out
);
  import hcv_pkg::*;

  // --------------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------------
  hcv_reg_if rif ();

  hcv_regs u_regs (
    .ref_clk_in  (ref_clk_in),
    .resetn_in   (resetn_in),
    .ce_in       (ce_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .irq_out     (irq_out),
    .rif         (rif)
  );

  // --------------------------------------------------------------------------
  // rounding selection
  // --------------------------------------------------------------------------
  hcv_rmode_t rmode;

  // only bit 2 and bits 1:0 of the immediate are looked at
  always_comb begin
    if (op_imm_in[HCV_IMM_SEL_BIT]) begin
      rmode = hcv_rmode_t'(rif.rounding_control_field);
    end else begin
      rmode = hcv_rmode_t'(op_imm_in[1:0]);
    end
  end

  // --------------------------------------------------------------------------
  // per-lane conversion
  // --------------------------------------------------------------------------
  logic [LANES*16-1:0]     n_pack;
  logic [LANES*32-1:0]     w_pack;
  logic [HCV_NFLAGS-1:0]   lane_flg [LANES];
  logic [LANES-1:0]        lane_snan;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [31:0]           s32;
    logic [15:0]           s16;
    // narrowing
    logic                  n_s;
    logic [7:0]            n_e;
    logic [22:0]           n_m;
    logic [7:0]            n_eeff;
    logic signed [9:0]     n_he;
    logic signed [9:0]     n_shw;
    logic [5:0]            n_sh;
    logic [49:0]           n_val;
    logic [10:0]           n_kept;
    logic                  n_rb;
    logic                  n_st;
    logic                  n_inc;
    logic [15:0]           n_sum;
    logic                  n_ovf;
    logic [15:0]           n_res;
    logic [HCV_NFLAGS-1:0] n_flg;
    logic                  n_snan;
    // widening
    logic                  w_s;
    logic [4:0]            w_e;
    logic [9:0]            w_m;
    logic [3:0]            w_p;
    logic [31:0]           w_res;
    logic [HCV_NFLAGS-1:0] w_flg;
    logic                  w_snan;

    assign s32 = op_src_in[g*32 +: 32];
    assign s16 = op_src_in[g*16 +: 16];

    // single to half; the flush-to-zero bit is never consulted here
    always_comb begin
      n_s    = s32[31];
      n_e    = s32[30:23];
      n_m    = s32[22:0];
      n_eeff = (n_e == 8'h00) ? 8'h01 : n_e;
      n_he   = $signed({2'b00, n_eeff}) - $signed({2'b00, HCV_EXP_REBIAS});
      n_shw  = (n_he > 10'sh000) ? HCV_RND_SHIFT : (HCV_RND_SHIFT + 10'sh001 - n_he);
      n_sh   = (n_shw > HCV_SHIFT_CAP) ? HCV_SHIFT_CAP[5:0] : n_shw[5:0];
      n_val  = {(n_e != 8'h00), n_m, 26'h000_0000} >> n_sh;
      n_kept = n_val[36:26];
      n_rb   = n_val[25];
      n_st   = |n_val[24:0];
      case (rmode)
        HCV_RN:  n_inc = n_rb && (n_st || n_kept[0]);
        HCV_RD:  n_inc = n_s && (n_rb || n_st);
        HCV_RU:  n_inc = !n_s && (n_rb || n_st);
        HCV_RZ:  n_inc = 1'b0;
        default: n_inc = 1'b0;
      endcase
      // carry out of the fraction walks into the exponent field
      n_sum  = {1'b0, (n_he > 10'sh000) ? n_he[4:0] : 5'h00, n_kept[9:0]}
               + {15'h0000, n_inc};
      n_ovf  = (n_he > HCV_F16_EXP_TOP) || (n_sum[14:10] == HCV_F16_EXP_MAX);
      n_flg  = '0;
      n_snan = 1'b0;
      n_res  = {n_s, n_sum[14:0]};
      if (n_e == HCV_F32_EXP_MAX) begin
        if (n_m == 23'h00_0000) begin
          n_res = {n_s, HCV_F16_EXP_MAX, 10'h000};
        end else begin
          // quiet bit forced high covers both NaN kinds
          n_res  = {n_s, HCV_F16_EXP_MAX, 1'b1, n_m[21:HCV_NAN_DROP-1]};
          n_snan = !n_m[22];
          n_flg[HCV_FLG_INV] = 1'b1;
        end
      end else begin
        n_flg[HCV_FLG_DEN] = (n_e == 8'h00) && (n_m != 23'h00_0000);
        n_flg[HCV_FLG_UNF] = (n_he < 10'sh001) && ((n_e != 8'h00) || (n_m != 23'h00_0000));
        n_flg[HCV_FLG_OVF] = n_ovf;
        n_flg[HCV_FLG_PRC] = n_rb || n_st || n_ovf;
        if (n_ovf) begin
          n_res = {n_s, HCV_F16_EXP_MAX, 10'h000};
        end
      end
    end

    // half to single is always exact; half values get no other treatment
    always_comb begin
      w_s    = s16[15];
      w_e    = s16[14:10];
      w_m    = s16[9:0];
      w_p    = 4'h0;
      for (int i = 0; i < 10; i++) begin
        if (w_m[i]) begin
          w_p = 4'(i);
        end
      end
      w_flg  = '0;
      w_snan = 1'b0;
      w_res  = {w_s, 31'h0000_0000};
      if (w_e == HCV_F16_EXP_MAX) begin
        if (w_m == 10'h000) begin
          w_res = {w_s, HCV_F32_EXP_MAX, 23'h00_0000};
        end else begin
          w_res  = {w_s, HCV_F32_EXP_MAX, 1'b1, w_m[8:0], 13'h0000};
          w_snan = !w_m[9];
          w_flg[HCV_FLG_INV] = 1'b1;
        end
      end else if (w_e != 5'h00) begin
        w_res = {w_s, {3'h0, w_e} + HCV_EXP_REBIAS, w_m, 13'h0000};
      end else if (w_m != 10'h000) begin
        // denormal source is normalised without touching the denormal flag
        w_res = {w_s, {4'h0, w_p} + HCV_SUB_EXP_BASE,
                 23'({w_m, 13'h0000} << (4'hA - w_p))};
      end
    end

    assign n_pack[g*16 +: 16] = n_res;
    assign w_pack[g*32 +: 32] = w_res;
    assign lane_flg[g]        = op_narrow_in ? n_flg : w_flg;
    assign lane_snan[g]       = op_narrow_in ? n_snan : w_snan;
  end

  // --------------------------------------------------------------------------
  // flag merge and exception decision
  // --------------------------------------------------------------------------
  logic [HCV_NFLAGS-1:0] flg_or;
  logic [HCV_NFLAGS-1:0] raise;
  logic [HCV_NFLAGS-1:0] msk;
  logic                  den_mix;
  logic                  suppress;
  logic                  exc;

  assign msk = rif.masks;

  always_comb begin
    flg_or = '0;
    for (int l = 0; l < LANES; l++) begin
      flg_or = flg_or | lane_flg[l];
    end
  end

  always_comb begin
    raise   = flg_or;
    den_mix = flg_or[HCV_FLG_DEN] && msk[HCV_FLG_DEN]
              && (!msk[HCV_FLG_PRC] || !msk[HCV_FLG_UNF]);
    if (den_mix) begin
      raise[HCV_FLG_UNF] = 1'b1;
      raise[HCV_FLG_PRC] = 1'b1;
    end
    // inexact alone never blocks the write; the rounded value still lands
    suppress = (|lane_snan && !msk[HCV_FLG_INV])
               || (raise[HCV_FLG_DEN] && !msk[HCV_FLG_DEN])
               || (raise[HCV_FLG_OVF] && !msk[HCV_FLG_OVF])
               || (raise[HCV_FLG_UNF] && !msk[HCV_FLG_UNF])
               || den_mix;
    // quiet NaN raises invalid but is no exception
    exc = |(raise & ~msk & ~{4'h0, !(|lane_snan)}) || den_mix;
  end

  assign rif.set_valid = op_valid_in;
  assign rif.set_flags = raise;

  // --------------------------------------------------------------------------
  // result register
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                  res_valid;
    logic                  res_write;
    logic [LANES*32-1:0]   res_data;
    logic                  exc;
    logic [HCV_NFLAGS-1:0] exc_flags;
  } hcv_core_state_t;

  hcv_core_state_t st;
  hcv_core_state_t next_st;

  always_comb begin
    next_st           = st;
    next_st.res_valid = op_valid_in;
    next_st.res_write = 1'b0;
    next_st.exc       = 1'b0;
    if (op_valid_in) begin
      next_st.res_write = !suppress;
      next_st.exc       = exc;
      next_st.exc_flags = raise;
      if (op_narrow_in) begin
        next_st.res_data = {{(LANES*16){1'b0}}, n_pack};
      end else begin
        next_st.res_data = w_pack;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign res_valid_out = st.res_valid;
  assign res_write_out = st.res_write;
  assign res_data_out  = st.res_data;
  assign exc_out       = st.exc;
  assign exc_flags_out = st.exc_flags;

endmodule // hcv_converter
`default_nettype wire

// ---- dv/hcv_converter_assertions.sv ----
// concurrent checks on the converter top ports
`timescale 1ns/10ps
`default_nettype none
module hcv_converter_assertions #(
  parameter int LANES = 4
) (
  // clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               resetn_in,
  input  wire logic               ce_in,
  // apb
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pready_out,
  // conversion
  input  wire logic               op_valid_in,
  input  wire logic               op_narrow_in,
  input  wire logic [LANES*32-1:0] op_src_in,
  input  wire logic               res_valid_out,
  input  wire logic               res_write_out,
  input  wire logic [LANES*32-1:0] res_data_out,
  input  wire logic               exc_out,
  input  wire logic [4:0]         exc_flags_out
);
  import hcv_pkg::*;
  // ------
  // properties
  // ------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  logic        take;
  logic [31:0] l0;
  assign take = op_valid_in && ce_in;
  assign l0   = op_src_in[31:0];
  // lane 0 only: other lanes may add flags through the or
  a_res_latency: assert property (take |=> res_valid_out)
    else $error("result not one cycle after op");
  a_out_qualified: assert property (res_write_out || exc_out |-> res_valid_out)
    else $error("write or exception without result valid");
  a_narrow_upper: assert property (take && op_narrow_in |=>
    !res_write_out || res_data_out[LANES*32-1:LANES*16] == '0)
    else $error("narrow result upper half not zero");
  a_nan_quiet: assert property (take && op_narrow_in && l0[30:23] == 8'hFF &&
    l0[22:0] != 0 |=> exc_flags_out[HCV_FLG_INV] && (!res_write_out ||
    (res_data_out[14:9] == 6'h3F && res_data_out[15] == $past(l0[31])
    && res_data_out[8:0] == $past(l0[21:13]))))
    else $error("narrowed nan wrong");
  a_den_tiny: assert property (take && op_narrow_in && l0[30:23] == 8'h00 &&
    l0[22:0] != 0 |=> exc_flags_out[HCV_FLG_DEN] && exc_flags_out[HCV_FLG_UNF])
    else $error("denormal source flags missing");
  a_widen_exact: assert property (take && !op_narrow_in |=> exc_flags_out[4:1] == 4'h0)
    else $error("widening raised numeric flag");
  a_ovf_inf: assert property (take && op_narrow_in && l0[30:23] >= 8'h8F &&
    l0[30:23] != 8'hFF |=> exc_flags_out[HCV_FLG_OVF]
    && (!res_write_out || res_data_out[14:0] == 15'h7C00))
    else $error("overflow not flagged or not infinity");
  a_flags_hold: assert property (!take |=> $stable(exc_flags_out))
    else $error("flags changed without op");
  a_apb_answer: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("apb answer late");
  c_narrow: cover property (take && op_narrow_in);
  c_widen: cover property (take && !op_narrow_in);
  c_exc: cover property (exc_out && !res_write_out);
endmodule // hcv_converter_assertions

bind hcv_converter hcv_converter_assertions #(.LANES(LANES)) u_hcv_chk (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out), .op_valid_in(op_valid_in),
  .op_narrow_in(op_narrow_in), .op_src_in(op_src_in), .res_valid_out(res_valid_out),
  .res_write_out(res_write_out), .res_data_out(res_data_out), .exc_out(exc_out),
  .exc_flags_out(exc_flags_out));
`default_nettype wire

// ---- dv/hcv_pipe_model.sv ----
// pipeline-side model issuing conversions and taking results
`timescale 1ns/10ps
`default_nettype none
module hcv_pipe_model #(
  parameter int LANES = 4
) (
  // clock
  input  wire logic               clk_in,
  // operation
  output var  logic               op_valid_out,
  output var  logic               op_narrow_out,
  output var  logic [7:0]         op_imm_out,
  output var  logic [LANES*32-1:0] op_src_out,
  // result
  input  wire logic               res_valid_in,
  input  wire logic               res_write_in,
  input  wire logic [LANES*32-1:0] res_data_in,
  input  wire logic               exc_in,
  input  wire logic [4:0]         exc_flags_in
);
  initial begin
    op_valid_out = 1'b0;
    op_narrow_out = 1'b0;
    op_imm_out = 8'h00;
    op_src_out = '0;
  end
  task automatic issue(input logic n, input logic [7:0] imm, input logic [LANES*32-1:0] s,
    output logic [LANES*32-1:0] res, output logic [4:0] f, output logic w, output logic x,
    output logic ok);
    ok = 1'b0;
    @(posedge clk_in);
    op_valid_out <= 1'b1;
    op_narrow_out <= n;
    op_imm_out <= imm;
    op_src_out <= s;
    @(posedge clk_in);
    op_valid_out <= 1'b0;
    // stale operands must not pass for fresh ones
    op_src_out <= ~s;
    op_imm_out <= ~imm;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk_in);
      ok = res_valid_in;
    end
    res = res_data_in;
    f = exc_flags_in;
    w = res_write_in;
    x = exc_in;
  endtask
endmodule // hcv_pipe_model
`default_nettype wire

// ---- dv/hcv_converter_tb.sv ----
// self-checking bench for the half/single converter
`timescale 1ns/10ps
`default_nettype none
module hcv_converter_tb;
  import hcv_pkg::*;
  localparam int LN = 4;
  logic             clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq, err;
  logic             opv, opn, resv, resw, exc;
  logic [7:0]       paddr, imm;
  logic [31:0]      pwdata, prdata, rd;
  logic [LN*32-1:0] src, res, rdat;
  logic [4:0]       flg, eflg;
  int               fail_count = 0;
  int               n_checks = 0;
  hcv_converter #(.LANES(LN)) DUT (.ref_clk_in(clk), .resetn_in(rst_n), .ce_in(ce),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .op_valid_in(opv), .op_narrow_in(opn), .op_imm_in(imm), .op_src_in(src),
    .res_valid_out(resv), .res_write_out(resw), .res_data_out(rdat), .exc_out(exc),
    .exc_flags_out(eflg), .irq_out(irq));
  hcv_pipe_model #(.LANES(LN)) u_pipe (.clk_in(clk), .op_valid_out(opv), .op_narrow_out(opn),
    .op_imm_out(imm), .op_src_out(src), .res_valid_in(resv), .res_write_in(resw),
    .res_data_in(rdat), .exc_in(exc), .exc_flags_in(eflg));
  // ------
  // helpers
  // ------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready ends this wait and only the watchdog bounds it; data is taken at the pready edge
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  task automatic conv(input logic n, input logic [7:0] im, input logic [127:0] s,
    input logic [127:0] er, input logic [4:0] ef, input logic ew, input logic ex);
    logic ok;
    logic w;
    logic x;
    u_pipe.issue(n, im, s, res, flg, w, x, ok);
    chk(ok, 1'b1, "latency");
    chk(flg, ef, "flags");
    chk(w, ew, "write");
    chk(x, ex, "exception");
    if (ew) chk(res, er, "result");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task automatic test_regs();
    apb(1'b0, HCV_OFF_CTRL, 32'h0);
    chk(rd, 32'h7C, "control reset");
    apb(1'b1, HCV_OFF_FEATURE, 32'h0);
    apb(1'b0, HCV_OFF_FEATURE, 32'h0);
    chk(rd, 32'h3000_0000, "feature bits");
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1, "unmapped error");
  endtask
  task automatic test_widen();
    apb(1'b1, HCV_OFF_IRQ_MASK, 32'h1);
    conv(1'b0, 8'h00, {64'h0, 64'hFC00_7E00_0001_3C00},
      128'hFF800000_7FC00000_33800000_3F800000, 5'h01, 1'b1, 1'b0);
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, HCV_OFF_STATUS, 32'h1F);
    @(negedge clk);
    chk(irq, 1'b0, "irq cleared");
  endtask
  task automatic test_round();
    logic [15:0] lo [4] = '{16'h3C01, 16'h3C00, 16'h3C01, 16'h3C00};
    logic [15:0] hi [4] = '{16'hBC01, 16'hBC01, 16'hBC00, 16'hBC00};
    for (int m = 0; m < 4; m++)
      conv(1'b1, 8'hF8 | 8'(m), {64'h0, 64'hBF801800_3F801800}, {96'h0, hi[m], lo[m]},
        5'h10, 1'b1, 1'b0);
    apb(1'b1, HCV_OFF_CTRL, 32'h7D);
    conv(1'b1, 8'h07, {64'h0, 64'hBF801800_3F801800}, {96'h0, 32'hBC01_3C00},
      5'h10, 1'b1, 1'b0);
    chk(irq, 1'b0, "irq masked");
  endtask
  task automatic test_nan();
    apb(1'b1, HCV_OFF_CTRL, 32'h7C);
    conv(1'b1, 8'h00, {64'h0, 64'h7F802000_FFC02000}, {96'h0, 32'h7E01_FE01},
      5'h01, 1'b1, 1'b0);
    apb(1'b1, HCV_OFF_CTRL, 32'h78);
    conv(1'b1, 8'h00, {96'h0, 32'h7F802000}, '0, 5'h01, 1'b0, 1'b1);
    conv(1'b1, 8'h00, {96'h0, 32'hFFC02000}, {112'h0, 16'hFE01}, 5'h01, 1'b1, 1'b0);
  endtask
  task automatic test_tiny();
    apb(1'b1, HCV_OFF_CTRL, 32'h7C);
    conv(1'b1, 8'h00, {96'h0, 32'h1}, '0, 5'h1A, 1'b1, 1'b0);
    apb(1'b1, HCV_OFF_CTRL, 32'h3C);
    conv(1'b1, 8'h00, {96'h0, 32'h1}, '0, 5'h1A, 1'b0, 1'b1);
    apb(1'b1, HCV_OFF_CTRL, 32'hFC);
    conv(1'b1, 8'h00, {96'h0, 32'h38000000}, {112'h0, 16'h0200}, 5'h08, 1'b1, 1'b0);
  endtask
  task automatic test_ovf();
    apb(1'b1, HCV_OFF_CTRL, 32'h7C);
    conv(1'b1, 8'h00, {64'h0, 64'hC7800000_47800000}, {96'h0, 32'hFC00_7C00},
      5'h14, 1'b1, 1'b0);
    apb(1'b1, HCV_OFF_CTRL, 32'h6C);
    conv(1'b1, 8'h00, {64'h0, 64'hC7800000_47800000}, '0, 5'h14, 1'b0, 1'b1);
    apb(1'b0, HCV_OFF_STATUS, 32'h0);
    chk(rd, 32'h1F, "sticky status");
  endtask
  // ------
  // sequence
  // ------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_widen();
    test_round();
    test_nan();
    test_tiny();
    test_ovf();
    summarize();
  end
  // whole run is about a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule // hcv_converter_tb
`default_nettype wire
